/* File: boost_pin_sync.v */
// boost-request pin synchroniser with polarity and enable
module boost_pin_sync (
    // clock and reset
    input  wire clk,
    input  wire rst,
    // pin and controls
    input  wire boost_pin,
    input  wire boost_pin_polarity,
    input  wire boost_pin_enable,
    // qualified request
    output wire boost_request
);

    reg sync1_reg;
    reg sync2_reg;

    // two-flop synchroniser for the asynchronous pin
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
        end else begin
            sync1_reg <= boost_pin;
            sync2_reg <= sync1_reg;
        end
    end

    // polarity 0 active low, 1 active high; ignored when disabled
    assign boost_request = boost_pin_enable & ~(sync2_reg ^ boost_pin_polarity);

endmodule

/* File: charger_chk.sv */
// port checker for the charger register bank
`include "charger_regs.vh"
module charger_chk (
    // clock, reset, register port
    input wire       clk,
    input wire       rst,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire       reg_wr,
    input wire       reg_rd,
    input wire [7:0] reg_rdata_reg,
    // power stage
    input wire       charge_active_reg,
    input wire       boost_active_reg,
    input wire [5:0] float_voltage_code_reg,
    input wire       param_reset_pulse_reg
);
    // decoded accesses
    wire       id_rd = reg_rd && reg_addr == `IDENT_ADDR;
    wire       wr_ct = reg_wr && reg_addr == `CTRL_ADDR;
    wire       wr_fl = reg_wr && reg_addr == `FLOAT_ADDR;
    wire       wr_rs = reg_wr && reg_addr == `ICHG_ADDR && reg_wdata[7];
    wire [5:0] wcode = reg_wdata[7:2];
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    property p_dis; wr_ct && reg_wdata[2] ##1 !reg_wr |=> !charge_active_reg; endproperty
    a_dis: assert property (p_dis) else $error("charge not stopped");
    property p_mode; wr_ct && reg_wdata[0] ##1 !reg_wr |=> boost_active_reg; endproperty
    a_mode: assert property (p_mode) else $error("boost not entered");
    property p_flt; wr_fl ##1 !reg_wr |=> float_voltage_code_reg == $past(wcode, 2); endproperty
    a_flt: assert property (p_flt) else $error("float code wrong");
    property p_sup; id_rd |=> reg_rdata_reg[7:5] == `IDENT_SUPPLIER; endproperty
    a_sup: assert property (p_sup) else $error("supplier wrong");
    property p_part; id_rd |=> reg_rdata_reg[4:2] == `IDENT_PART; endproperty
    a_part: assert property (p_part) else $error("part wrong");
    property p_revision; id_rd |=> reg_rdata_reg[1:0] == `IDENT_REVISION; endproperty
    a_revision: assert property (p_revision) else $error("revision wrong");
    property p_rst; wr_rs ##1 !reg_wr |=> float_voltage_code_reg == 6'h02; endproperty
    a_rst: assert property (p_rst) else $error("defaults not restored");
    property p_pls; wr_rs |=> param_reset_pulse_reg ##1 !param_reset_pulse_reg; endproperty
    a_pls: assert property (p_pls) else $error("reset pulse wrong");
endmodule
bind charger_control_registers charger_chk chk (
    .clk                    (clk),
    .rst                    (rst),
    .reg_addr               (reg_addr),
    .reg_wdata              (reg_wdata),
    .reg_wr                 (reg_wr),
    .reg_rd                 (reg_rd),
    .reg_rdata_reg          (reg_rdata_reg),
    .charge_active_reg      (charge_active_reg),
    .boost_active_reg       (boost_active_reg),
    .float_voltage_code_reg (float_voltage_code_reg),
    .param_reset_pulse_reg  (param_reset_pulse_reg)
);

/* File: charger_control_registers.v */
// register bank of the switching charger: control, float voltage, identity, parameter reset
`include "charger_regs.vh"

module charger_control_registers (
    // clock and reset
    input  wire       clk,
    input  wire       rst,
    // register access from the serial control front end
    input  wire [7:0] reg_addr,
    input  wire [7:0] reg_wdata,
    input  wire       reg_wr,
    input  wire       reg_rd,
    output reg  [7:0] reg_rdata_reg,
    output reg        reg_rvalid_reg,
    // external boost-request pin
    input  wire       boost_pin,
    // controls to the power stage
    output reg        charge_active_reg,
    output reg        boost_active_reg,
    output reg        safety_timer_32s_run_reg,
    output reg  [5:0] float_voltage_code_reg,
    output reg        param_reset_pulse_reg
);

    // reset values and write mask, sized once so every use keeps its width
    localparam [7:0] CTRL_DEFAULT  = `CTRL_RESET;
    localparam [7:0] FLOAT_DEFAULT = `FLOAT_RESET;
    localparam [7:0] ICHG_DEFAULT  = `ICHG_RESET;
    localparam [7:0] CTRL_WR_MASK  = (8'h01 << `CTRL_DISABLE_BIT) | (8'h01 << `CTRL_MODE_BIT);

    // register state and next values
    reg  [7:0] ctrl_reg;
    reg  [7:0] ctrl_next;
    reg  [7:0] float_reg;
    reg  [7:0] float_next;
    reg  [6:0] ichg_reg;
    reg  [6:0] ichg_next;
    reg  [7:0] rdata_next;
    // power-stage next values
    reg        charge_active_next;
    reg        boost_active_next;
    reg        safety_timer_32s_run_next;
    // address decode and write strobes
    wire       ctrl_sel;
    wire       float_sel;
    wire       ident_sel;
    wire       ichg_sel;
    wire       ctrl_wr;
    wire       float_wr;
    wire       ichg_wr;
    // register fields
    wire       charge_disable;
    wire       operating_mode_select;
    wire       boost_pin_polarity;
    wire       boost_pin_enable;
    wire [5:0] float_voltage_code;
    // identity fields
    wire [2:0] supplier_field;
    wire [2:0] part_number_field;
    wire [1:0] revision_field;
    wire [7:0] ident_value;
    // derived controls
    wire       param_reset;
    wire       boost_request;
    wire       mode_boost;

    // qualified boost request from the external pin
    boost_pin_sync pin_sync (
        .clk                (clk),
        .rst                (rst),
        .boost_pin          (boost_pin),
        .boost_pin_polarity (boost_pin_polarity),
        .boost_pin_enable   (boost_pin_enable),
        .boost_request      (boost_request)
    );

    // address decode
    assign ctrl_sel  = (reg_addr == `CTRL_ADDR);
    assign float_sel = (reg_addr == `FLOAT_ADDR);
    assign ident_sel = (reg_addr == `IDENT_ADDR);
    assign ichg_sel  = (reg_addr == `ICHG_ADDR);

    // write strobes; the identity register takes none
    assign ctrl_wr  = reg_wr & ctrl_sel;
    assign float_wr = reg_wr & float_sel;
    assign ichg_wr  = reg_wr & ichg_sel;

    // write of 1 to the reset bit; acts only in the cycle of the write
    assign param_reset = ichg_wr & reg_wdata[`ICHG_RESET_BIT];

    // register fields
    assign charge_disable        = ctrl_reg[`CTRL_DISABLE_BIT];
    assign operating_mode_select = ctrl_reg[`CTRL_MODE_BIT];
    assign boost_pin_polarity    = float_reg[`FLOAT_POL_BIT];
    assign boost_pin_enable      = float_reg[`FLOAT_EN_BIT];
    assign float_voltage_code    = float_reg[`FLOAT_CODE_MSB:`FLOAT_CODE_LSB];

    // fixed identity word: supplier, part number, revision
    assign supplier_field    = `IDENT_SUPPLIER;
    assign part_number_field = `IDENT_PART;
    assign revision_field    = `IDENT_REVISION;
    assign ident_value       = {supplier_field, part_number_field, revision_field};

    // effective mode: register bit or honoured pin request
    assign mode_boost = operating_mode_select | boost_request;

    // control register; only disable and mode bits are stored
    always @* begin
        ctrl_next = ctrl_reg;
        if (param_reset) begin
            ctrl_next = CTRL_DEFAULT;
        end else if (ctrl_wr) begin
            ctrl_next = reg_wdata & CTRL_WR_MASK;
        end
    end

    // float-voltage register with pin polarity and enable
    always @* begin
        float_next = float_reg;
        if (param_reset) begin
            float_next = FLOAT_DEFAULT;
        end else if (float_wr) begin
            float_next = reg_wdata;
        end
    end

    // charge-current storage; bit 7 is write-only and never stored
    always @* begin
        ichg_next = ichg_reg;
        if (param_reset) begin
            ichg_next = ICHG_DEFAULT[6:0];
        end else if (ichg_wr) begin
            ichg_next = reg_wdata[6:0];
        end
    end

    // read multiplexer; unmapped addresses read zero
    always @* begin
        rdata_next = 8'h00;
        if (ctrl_sel) begin
            rdata_next = ctrl_reg;
        end else if (float_sel) begin
            rdata_next = float_reg;
        end else if (ident_sel) begin
            rdata_next = ident_value;
        end else if (ichg_sel) begin
            rdata_next = {1'b0, ichg_reg}; // write-only bit reads 0
        end
    end

    // register state
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_reg  <= CTRL_DEFAULT;
            float_reg <= FLOAT_DEFAULT;
            ichg_reg  <= ICHG_DEFAULT[6:0];
        end else begin
            ctrl_reg  <= ctrl_next;
            float_reg <= float_next;
            ichg_reg  <= ichg_next;
        end
    end

    // read valid, one cycle after the strobe
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            reg_rvalid_reg <= 1'b0;
        end else begin
            reg_rvalid_reg <= reg_rd;
        end
    end

    // read data, held until the next read
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            reg_rdata_reg <= 8'h00;
        end else begin
            if (reg_rd) begin
                reg_rdata_reg <= rdata_next;
            end
        end
    end

    // power-stage decisions; the disable bit leaves the safety timer alone
    always @* begin
        boost_active_next         = mode_boost;
        charge_active_next        = ~charge_disable & ~mode_boost;
        safety_timer_32s_run_next = ~mode_boost;
    end

    // controls to the power stage
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            charge_active_reg        <= 1'b0;
            boost_active_reg         <= 1'b0;
            safety_timer_32s_run_reg <= 1'b0;
            float_voltage_code_reg   <= FLOAT_DEFAULT[`FLOAT_CODE_MSB:`FLOAT_CODE_LSB];
        end else begin
            charge_active_reg        <= charge_active_next;
            boost_active_reg         <= boost_active_next;
            safety_timer_32s_run_reg <= safety_timer_32s_run_next;
            float_voltage_code_reg   <= float_voltage_code;
        end
    end

    // parameter-reset pulse, one cycle per reset write
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            param_reset_pulse_reg <= 1'b0;
        end else begin
            param_reset_pulse_reg <= param_reset;
        end
    end

endmodule

/* File: charger_control_registers_test.sv */
// self-checking bench for the charger register bank
`include "charger_regs.vh"
module charger_control_registers_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic       boost_pin = 1'b0;
    logic [7:0] q;
    int         fail_count = 0;
    int         compares = 0;
    wire  [7:0] reg_addr, reg_wdata, reg_rdata_reg;
    wire  [5:0] float_voltage_code_reg;
    wire        reg_wr, reg_rd, reg_rvalid_reg, charge_active_reg, boost_active_reg;
    wire        safety_timer_32s_run_reg, param_reset_pulse_reg;
    wire  [7:0] st = {5'h00, charge_active_reg, boost_active_reg, safety_timer_32s_run_reg};
    // clock and instances
    always #2.5 clk = ~clk;
    charger_control_registers uut (
        .clk                      (clk),
        .rst                      (rst),
        .reg_addr                 (reg_addr),
        .reg_wdata                (reg_wdata),
        .reg_wr                   (reg_wr),
        .reg_rd                   (reg_rd),
        .reg_rdata_reg            (reg_rdata_reg),
        .reg_rvalid_reg           (reg_rvalid_reg),
        .boost_pin                (boost_pin),
        .charge_active_reg        (charge_active_reg),
        .boost_active_reg         (boost_active_reg),
        .safety_timer_32s_run_reg (safety_timer_32s_run_reg),
        .float_voltage_code_reg   (float_voltage_code_reg),
        .param_reset_pulse_reg    (param_reset_pulse_reg)
    );
    reg_host host (
        .clk            (clk),
        .reg_addr       (reg_addr),
        .reg_wdata      (reg_wdata),
        .reg_wr         (reg_wr),
        .reg_rd         (reg_rd),
        .reg_rdata_reg  (reg_rdata_reg),
        .reg_rvalid_reg (reg_rvalid_reg)
    );
    // compare and count
    task automatic check(input logic [7:0] got, exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // read and compare, write and settle, drive pin and look
    task automatic rdc(input logic [7:0] a, exp);
        host.xfer(a, 8'h00, 1'b0, q);
        check(q, exp);
    endtask
    task automatic wr(input logic [7:0] a, d);
        host.xfer(a, d, 1'b1, q);
        repeat (2) @(posedge clk);
    endtask
    task automatic look(input logic p, input logic [7:0] exp);
        boost_pin <= p;
        repeat (6) @(posedge clk);
        check(st, exp);
    endtask
    task automatic wrap_up();
        if (fail_count == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // watchdog
    initial begin
        #20000;
        fail_count++;
        wrap_up();
    end
    // test sequence
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        look(1'b0, 8'h05);
        rdc(`CTRL_ADDR, `CTRL_RESET);
        rdc(`FLOAT_ADDR, `FLOAT_RESET);
        rdc(`IDENT_ADDR, {`IDENT_SUPPLIER, `IDENT_PART, `IDENT_REVISION});
        rdc(`ICHG_ADDR, 8'h09);
        rdc(8'h7F, 8'h00);
        wr(`CTRL_ADDR, 8'hFF);
        look(1'b0, 8'h02);
        rdc(`CTRL_ADDR, 8'h05);
        wr(`CTRL_ADDR, 8'h04);
        look(1'b0, 8'h01);
        wr(`IDENT_ADDR, 8'h00);
        rdc(`IDENT_ADDR, {`IDENT_SUPPLIER, `IDENT_PART, `IDENT_REVISION});
        wr(`FLOAT_ADDR, 8'hFF);
        check({2'h0, float_voltage_code_reg}, 8'h3F);
        look(1'b1, 8'h02);
        look(1'b0, 8'h01);
        wr(`FLOAT_ADDR, 8'h01);
        look(1'b0, 8'h02);
        wr(`FLOAT_ADDR, 8'h00);
        look(1'b0, 8'h01);
        wr(`ICHG_ADDR, 8'h7F);
        rdc(`ICHG_ADDR, 8'h7F);
        wr(`ICHG_ADDR, 8'hC3);
        rdc(`ICHG_ADDR, 8'h09);
        rdc(`CTRL_ADDR, `CTRL_RESET);
        look(1'b0, 8'h05);
        wrap_up();
    end
endmodule

/* File: charger_regs.vh */
// register offsets, field positions, reset values and identity values of the charger bank
`ifndef CHARGER_REGS_VH
`define CHARGER_REGS_VH

// register offsets
`define CTRL_ADDR          8'h01
`define FLOAT_ADDR         8'h02
`define IDENT_ADDR         8'h03
`define ICHG_ADDR          8'h04

// control register fields
`define CTRL_DISABLE_BIT   2
`define CTRL_MODE_BIT      0
`define CTRL_RESET         8'h00

// float-voltage register fields
`define FLOAT_CODE_MSB     7
`define FLOAT_CODE_LSB     2
`define FLOAT_POL_BIT      1
`define FLOAT_EN_BIT       0
`define FLOAT_RESET        8'h0A

// charge-current register fields
`define ICHG_RESET_BIT     7
`define ICHG_RESET         8'h89

// identity fields, values arbitrary
`define IDENT_SUPPLIER     3'h2
`define IDENT_PART         3'h3
`define IDENT_REVISION     2'h1

`endif

/* File: reg_host.sv */
// host model driving the register strobe port
module reg_host (
    // clock
    input  wire        clk,
    // strobe port
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic       reg_wr,
    output logic       reg_rd,
    // read answer
    input  wire  [7:0] reg_rdata_reg,
    input  wire        reg_rvalid_reg
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {reg_addr, reg_wdata, reg_wr, reg_rd} = 18'h00000;
    // one access: strobe one cycle, scramble data, fetch answer
    task automatic xfer(input logic [7:0] a, d, input logic w, output logic [7:0] q);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= w;
        reg_rd    <= !w;
        @(posedge clk);
        reg_wr    <= 1'b0;
        reg_rd    <= 1'b0;
        reg_wdata <= ~d; // stale data never lingers
        @(posedge clk);
        q = reg_rvalid_reg ? reg_rdata_reg : 8'hXX;
    endtask
endmodule
